// File: logic/exb_master.sv
/*
  Expansion bus master: CPU write FIFO, area decode, four DMA
  channels, CPU/DMA arbitration, error flags, 16-bit link.
  Assumes the link clock, target pins and interrupt lines are
  asynchronous; the memory port and register port run on clk_sys.
*/
// Added by the designer: the address-and-strobe port and the placing of the registers.
`include "exb_map.svh"
`timescale 1ns/10ps
`default_nettype none
module exb_master #(
  parameter int unsigned NCH     = 4,
  parameter int unsigned TMO_CYC = `EXB_TMO_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic              cpu_req,
  input  wire logic              cpu_we,
  input  wire logic [31:0]       cpu_addr,
  input  wire exb_pkg::exb_size_t cpu_size,
  input  wire logic [31:0]       cpu_wdata,
  output logic                   cpu_ready,
  output logic                   cpu_rvalid,
  output logic [31:0]            cpu_rdata,
  output logic                   cpu_err,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [31:0]            mem_addr,
  output logic [31:0]            mem_wdata,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_ack,
  input  wire logic              ext_clk,
  output logic                   ext_frame,
  output logic                   ext_write,
  output exb_pkg::exb_size_t     ext_size,
  output logic [15:0]            ext_ad_o,
  input  wire logic [15:0]       ext_ad_i,
  output logic                   ext_ad_oe_n,
  input  wire logic              ext_ack,
  input  wire logic              ext_dreq,
  input  wire logic [2:0]        ext_irq,
  output logic [2:0]             irq_out,
  output logic                   irq_err
);
  import exb_pkg::*;

  if (NCH != 4 || TMO_CYC < 2 || TMO_CYC > 65535) begin : g_chk
    $error("exb_master: NCH must be 4, TMO_CYC 2..65535");
  end

  // ============================================================
  // pin synchronisers
  logic [21:0] sy1, sy2;
  logic        lck;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sy1 <= '0;
      sy2 <= '0;
      lck <= 1'b0;
    end else begin
      sy1 <= {ext_clk, ext_ack, ext_dreq, ext_irq, ext_ad_i};
      sy2 <= sy1;
      lck <= sy2[21];
    end
  end
  logic rise, ack_s, dreq_s;
  logic [2:0]  irq_s;
  logic [15:0] adin;
  assign rise   = sy2[21] & ~lck;
  assign ack_s  = sy2[20];
  assign dreq_s = sy2[19];
  assign irq_s  = sy2[18:16];
  assign adin   = sy2[15:0];

  // ============================================================
  // registers and shared state
  logic             cfg_burst;
  logic [31:0]      prot;
  logic [7:0]       err;
  logic [31:0]      ba [NCH];
  logic [31:0]      ma [NCH];
  logic [15:0]      len [NCH];
  logic [NCH-1:0]   dir, trg, act, vld, setbad, dwant;
  logic [NCH-1:0]   u_ok, u_ab;
  exb_state_t       st;
  logic [31:0]      xaddr, xmem;
  logic [31:0]      xbuf [8];
  exb_size_t        xsz;
  logic             xwr, xdma, xasy;
  logic [1:0]       xch, rrp;
  logic [3:0]       bidx, nb;
  logic [2:0]       widx;
  logic [15:0]      tmo;
  logic             last_dma;

  // ============================================================
  // CPU front end and write FIFO
  logic [31:0] f_addr [8];
  logic [31:0] f_data [8];
  exb_size_t   f_size [8];
  logic [2:0]  wp, rp;
  logic [3:0]  cnt, next_cnt, popn;
  logic        rdp, next_rdp, next_ready, bb, next_bb;
  logic [31:0] rd_addr;
  exb_size_t   rd_sz;
  exb_area_t   area;
  logic        szok, acc, acc_ok, bad, push, rd_acc, ctl_rd;
  logic        head_b, cpu_wr_rdy, cpu_rd_rdy, cpu_want;
  logic        g_any, pick_dma, g_cpu_w, fin, tmo_hit;
  logic [1:0]  gch;
  exb_size_t   head_nx;

  always_comb begin
    area = exb_decode(cpu_addr);
    case (area)
      EXB_A_CTL: szok = cpu_size == EXB_SZ4
                        && cpu_addr[1:0] == 2'h0;
      EXB_A_ASY: szok = cpu_size != EXB_SZ32
                        && cpu_addr[1:0] == 2'h0;
      EXB_A_SYN: szok = cpu_size == EXB_SZ1
                        || (cpu_size == EXB_SZ2 && !cpu_addr[0])
                        || cpu_addr[1:0] == 2'h0;
      default:   szok = 1'b0;
    endcase
    if (cpu_size == EXB_SZ32 && !cpu_we) szok = 1'b0;
  end

  assign acc    = cpu_req & cpu_ready;
  assign acc_ok = acc & szok & (area == EXB_A_ASY || area == EXB_A_SYN);
  assign ctl_rd = acc & szok & area == EXB_A_CTL & ~cpu_we;
  assign bad    = acc & ~szok;
  assign push   = acc_ok & cpu_we;
  assign rd_acc = acc_ok & ~cpu_we;

  assign head_b     = cfg_burst & f_size[rp] == EXB_SZ32;
  assign cpu_wr_rdy = cnt != 4'h0 & (~head_b | cnt == 4'h8);
  assign cpu_rd_rdy = rdp & cnt == 4'h0;
  assign cpu_want   = cpu_wr_rdy | cpu_rd_rdy;
  assign g_any      = st == EXB_IDLE & (cpu_want | (|dwant));
  assign pick_dma   = (|dwant) & (~cpu_want | ~last_dma);
  assign g_cpu_w    = g_any & ~pick_dma & ~cpu_rd_rdy;
  assign popn       = g_cpu_w ? (head_b ? 4'h8 : 4'h1) : 4'h0;
  assign next_cnt   = cnt + {3'h0, push} - popn;

  assign tmo_hit = st == EXB_BEAT & tmo == 16'(TMO_CYC - 1);
  assign fin     = st == EXB_BEAT
                   & ((rise & ack_s & bidx == nb) | tmo_hit);
  assign next_rdp = (rdp | rd_acc) & ~(fin & ~xdma & ~xwr);
  assign bb       = st != EXB_IDLE & ~xdma & xsz == EXB_SZ32;
  assign next_bb  = (bb & ~fin) | (g_cpu_w & head_b);
  assign head_nx  = cnt == 4'h0 ? cpu_size : f_size[rp];

  always_comb begin
    if (cfg_burst)
      // a queued non-burst word, a full 8-word burst or a burst on the link holds the CPU off
      next_ready = (next_cnt == 4'h0 & ~next_bb)
                   | (next_cnt != 4'h0 & next_cnt < 4'h8
                      & head_nx == EXB_SZ32);
    else
      next_ready = next_cnt < 4'h8;
    if (next_rdp) next_ready = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp        <= 3'h0;
      rp        <= 3'h0;
      cnt       <= 4'h0;
      rdp       <= 1'b0;
      cpu_ready <= 1'b0;
      cpu_err   <= 1'b0;
      rd_addr   <= 32'h0;
      rd_sz     <= EXB_SZ1;
    end else begin
      if (push) wp <= wp + 3'h1;
      rp        <= rp + popn[2:0];
      cnt       <= next_cnt;
      rdp       <= next_rdp;
      cpu_ready <= next_ready;
      cpu_err   <= bad | (fin & tmo_hit & ~xdma & ~xwr);
      if (rd_acc) begin
        rd_addr <= cpu_addr;
        rd_sz   <= cpu_size;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      f_addr[wp] <= cpu_addr;
      f_data[wp] <= cpu_wdata;
      f_size[wp] <= cpu_size;
    end
  end

  // ============================================================
  // round-robin channel pick, starting after the last winner
  always_comb begin
    gch = rrp;
    for (int k = 4; k >= 1; k--) begin
      if (dwant[2'(int'(rrp) + k)]) gch = 2'(int'(rrp) + k);
    end
  end

  // ============================================================
  // transfer engine: memory reads before link beats, memory writes after
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st         <= EXB_IDLE;
      xaddr      <= 32'h0;
      xmem       <= 32'h0;
      xsz        <= EXB_SZ1;
      xwr        <= 1'b0;
      xdma       <= 1'b0;
      xasy       <= 1'b0;
      xch        <= 2'h0;
      bidx       <= 4'h0;
      nb         <= 4'h0;
      widx       <= 3'h0;
      tmo        <= 16'h0;
      last_dma   <= 1'b0;
      rrp        <= 2'h3;
      u_ok       <= '0;
      u_ab       <= '0;
      cpu_rvalid <= 1'b0;
      cpu_rdata  <= 32'h0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= 32'h0;
      mem_wdata  <= 32'h0;
    end else begin
      u_ok       <= '0;
      u_ab       <= '0;
      cpu_rvalid <= ctl_rd;
      if (ctl_rd) cpu_rdata <= 32'h0;
      if (st == EXB_BEAT) tmo <= (rise & ack_s) ? 16'h0 : tmo + 16'h1;
      case (st)
        EXB_IDLE: begin
          if (g_any) begin
            last_dma <= pick_dma;
            xdma     <= pick_dma;
            xasy     <= 1'b0;
            if (pick_dma) begin
              rrp   <= gch;
              xch   <= gch;
              xaddr <= ba[gch];
              xmem  <= ma[gch];
              xsz   <= EXB_SZ32;
              nb    <= 4'hF;
              xwr   <= ~dir[gch];
              if (!dir[gch]) begin
                st       <= EXB_MRD;
                widx     <= 3'h0;
                mem_req  <= 1'b1;
                mem_we   <= 1'b0;
                mem_addr <= ma[gch];
              end else begin
                st <= EXB_AH;
              end
            end else if (cpu_rd_rdy) begin
              st    <= EXB_AH;
              xaddr <= rd_addr;
              xsz   <= rd_sz;
              xwr   <= 1'b0;
              xasy  <= exb_decode(rd_addr) == EXB_A_ASY;
              nb    <= rd_sz == EXB_SZ4 ? 4'h1 : 4'h0;
            end else begin
              st   <= EXB_AH;
              xwr  <= 1'b1;
              for (int j = 0; j < 8; j++)
                xbuf[j] <= f_data[rp + 3'(j)];
              if (head_b) begin
                xaddr <= {f_addr[rp][31:5], 5'h0};
                xsz   <= EXB_SZ32;
                nb    <= 4'hF;
              end else begin
                xaddr <= f_addr[rp];
                // a lone burst word in word mode goes out as 4 bytes
                xsz   <= f_size[rp] == EXB_SZ32 ? EXB_SZ4 : f_size[rp];
                nb    <= f_size[rp][1] ? 4'h1 : 4'h0;
              end
            end
          end
        end
        EXB_MRD: begin
          if (mem_ack) begin
            xbuf[widx] <= mem_rdata;
            widx       <= widx + 3'h1;
            mem_addr   <= mem_addr + 32'h4;
            if (widx == 3'h7) begin
              mem_req <= 1'b0;
              st      <= EXB_AH;
            end
          end
        end
        EXB_AH: if (rise) st <= EXB_AL;
        EXB_AL: begin
          if (rise) begin
            st   <= EXB_BEAT;
            bidx <= 4'h0;
            tmo  <= 16'h0;
          end
        end
        EXB_BEAT: begin
          if (rise & ack_s & !xwr) begin
            if (bidx[0]) xbuf[bidx[3:1]][31:16] <= adin;
            else         xbuf[bidx[3:1]][15:0]  <= adin;
          end
          if (fin) begin
            st <= EXB_IDLE;
            if (xdma) begin
              if (tmo_hit) begin
                u_ab[xch] <= 1'b1;
              end else if (!xwr) begin
                st        <= EXB_MWR;
                widx      <= 3'h0;
                mem_req   <= 1'b1;
                mem_we    <= 1'b1;
                mem_addr  <= xmem;
                mem_wdata <= xbuf[0];
              end else begin
                u_ok[xch] <= 1'b1;
              end
            end else if (!xwr) begin
              cpu_rvalid <= ~tmo_hit;
              if (xasy)
                cpu_rdata <= {24'h0, xsz == EXB_SZ4 ? xbuf[0][7:0]
                                                    : adin[7:0]};
              else if (xsz == EXB_SZ4)
                cpu_rdata <= {adin, xbuf[0][15:0]};
              else
                cpu_rdata <= {16'h0, adin};
            end
          end else if (rise & ack_s) begin
            bidx <= bidx + 4'h1;
          end
        end
        EXB_MWR: begin
          if (mem_ack) begin
            widx <= widx + 3'h1;
            if (widx == 3'h7) begin
              mem_req   <= 1'b0;
              u_ok[xch] <= 1'b1;
              st        <= EXB_IDLE;
            end else begin
              mem_addr  <= mem_addr + 32'h4;
              mem_wdata <= xbuf[widx + 3'h1];
            end
          end
        end
        default: st <= EXB_IDLE;
      endcase
    end
  end

  // ============================================================
  // link pins; AD lines released to the target in read beats, targets never master
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_frame   <= 1'b0;
      ext_write   <= 1'b0;
      ext_size    <= EXB_SZ1;
      ext_ad_o    <= 16'h0;
      ext_ad_oe_n <= 1'b1;
    end else begin
      ext_frame   <= st == EXB_AH | st == EXB_AL | st == EXB_BEAT;
      ext_write   <= xwr;
      ext_size    <= xsz;
      ext_ad_oe_n <= ~(st == EXB_AH | st == EXB_AL
                       | (st == EXB_BEAT & xwr));
      case (st)
        EXB_AH:  ext_ad_o <= xaddr[31:16];
        EXB_AL:  ext_ad_o <= xaddr[15:0];
        default: ext_ad_o <= bidx[0] ? xbuf[bidx[3:1]][31:16]
                                     : xbuf[bidx[3:1]][15:0];
      endcase
    end
  end

  // ============================================================
  // DMA channels
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic cw, inwin, aud, aok;
    assign cw    = reg_wr & reg_addr[7:4] == 4'(`EXB_R_CH0 + i);
    assign aok   = exb_decode(ba[i]) == EXB_A_SYN;
    assign aud   = (ba[i] >= `EXB_AUD_LO && ba[i] <= `EXB_AUD_HI)
                   || (ba[i] >= `EXB_MIR_LO && ba[i] <= `EXB_MIR_HI);
    assign inwin = ma[i][31:16] >= prot[15:0]
                   && ma[i][31:16] <= prot[31:16];
    assign vld[i] = len[i] != 16'h0 && ba[i][4:0] == 5'h0
                    && ma[i][4:0] == 5'h0 && aok
                    && (i != 0 || (!reg_wdata[`EXB_F_DIR]
                                   && aud && inwin));
    assign setbad[i] = cw & reg_addr[3:2] == `EXB_O_CTL
                       & reg_wdata[`EXB_F_EN] & ~act[i] & ~vld[i];
    assign dwant[i] = act[i] & (~trg[i] | dreq_s);

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        ba[i]  <= 32'h0;
        ma[i]  <= 32'h0;
        len[i] <= 16'h0;
        dir[i] <= 1'b0;
        trg[i] <= 1'b0;
        act[i] <= 1'b0;
      end else if (u_ok[i]) begin
        ba[i]  <= ba[i] + `EXB_UNIT;
        ma[i]  <= ma[i] + `EXB_UNIT;
        len[i] <= len[i] - 16'h1;
        if (len[i] == 16'h1) act[i] <= 1'b0;
      end else if (u_ab[i]) begin
        act[i] <= 1'b0;
      end else if (cw) begin
        case (reg_addr[3:2])
          `EXB_O_BUS: ba[i]  <= reg_wdata;
          `EXB_O_MEM: ma[i]  <= reg_wdata;
          `EXB_O_LEN: len[i] <= reg_wdata[15:0];
          default: begin
            dir[i] <= reg_wdata[`EXB_F_DIR];
            trg[i] <= reg_wdata[`EXB_F_TRG];
            if (!reg_wdata[`EXB_F_EN]) act[i] <= 1'b0;
            else if (!act[i]) act[i] <= vld[i];
          end
        endcase
      end
    end
  end

  // ============================================================
  // control, protection window, error flags, interrupt pass-through
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_burst <= 1'b0;
      prot      <= `EXB_PROT_RST;
      err       <= 8'h0;
      irq_out   <= 3'h0;
      irq_err   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `EXB_R_CFG) cfg_burst <= reg_wdata[0];
      if (reg_wr && reg_addr == `EXB_R_PROT) prot <= reg_wdata;
      // a new event wins over a clear in the same cycle
      err <= (err & ~((reg_wr && reg_addr == `EXB_R_ERR)
                      ? reg_wdata[7:0] : 8'h0))
             | {setbad, 1'b0, fin & tmo_hit & xdma,
                bad & area != EXB_A_NONE,
                fin & tmo_hit & ~xdma};
      irq_out <= irq_s;
      irq_err <= |err;
    end
  end

  // ============================================================
  // register read port
  logic [3:0] rch;
  assign rch = reg_addr[7:4] - `EXB_R_CH0;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        if (reg_addr == `EXB_R_CFG) reg_rdata <= {31'h0, cfg_burst};
        if (reg_addr == `EXB_R_STAT)
          reg_rdata <= 32'({act, 1'b0, irq_s, 1'b0, st != EXB_IDLE,
                            rdp, cnt, cnt == 4'h0});
        if (reg_addr == `EXB_R_ERR) reg_rdata <= {24'h0, err};
        if (reg_addr == `EXB_R_PROT) reg_rdata <= prot;
        if (reg_addr[1:0] == 2'h0 && rch < 4'(NCH)) begin
          case (reg_addr[3:2])
            `EXB_O_BUS: reg_rdata <= ba[rch[1:0]];
            `EXB_O_MEM: reg_rdata <= ma[rch[1:0]];
            `EXB_O_LEN: reg_rdata <= {16'h0, len[rch[1:0]]};
            default:    reg_rdata <= {28'h0, act[rch[1:0]],
                                      trg[rch[1:0]], dir[rch[1:0]],
                                      act[rch[1:0]]};
          endcase
        end
      end
    end
  end
endmodule : exb_master
`default_nettype wire

// File: logic/exb_map.svh
/*
  Address areas, register offsets, field positions, reset values and
  timing counts of the expansion bus master. Definitions only.
  Assumes a 100 MHz system clock.
*/
`ifndef EXB_MAP_SVH
`define EXB_MAP_SVH
// ============================================================
// physical address areas
`define EXB_CTL_LO  32'h005F_7800
`define EXB_CTL_HI  32'h005F_78FF
`define EXB_CTT_HI  32'h005F_7BFF
`define EXB_ASY_LO  32'h0060_0000
`define EXB_ASY_HI  32'h0060_07FF
`define EXB_S16_LO  32'h0062_0000
`define EXB_S16_HI  32'h0062_FFFF
`define EXB_MOD_HI  32'h0067_FFFF
`define EXB_AUD_LO  32'h0070_0000
`define EXB_AUD_HI  32'h00FF_FFFF
`define EXB_S32_HI  32'h01FF_FFFF
`define EXB_MIR_LO  32'h0270_0000
`define EXB_MIR_HI  32'h02FF_FFFF
`define EXB_S3B_HI  32'h03FF_FFFF
`define EXB_EXP_LO  32'h1400_0000
`define EXB_EXP_HI  32'h17FF_FFFF
// ============================================================
// register port offsets and fields
`define EXB_R_CFG   8'h00
`define EXB_R_STAT  8'h04
`define EXB_R_ERR   8'h08
`define EXB_R_PROT  8'h0C
`define EXB_R_CH0   4'h2
`define EXB_O_BUS   2'h0
`define EXB_O_MEM   2'h1
`define EXB_O_LEN   2'h2
`define EXB_O_CTL   2'h3
`define EXB_F_EN    0
`define EXB_F_DIR   1
`define EXB_F_TRG   2
`define EXB_PROT_RST 32'hFFFF_0000
`define EXB_UNIT    32'h0000_0020
// ============================================================
// timing
`define EXB_CLK_MHZ 100
`define EXB_TMO_NS  16000
`define EXB_TMO_CYC ((`EXB_TMO_NS * `EXB_CLK_MHZ) / 1000)
`endif

// File: logic/exb_pkg.sv
/*
  Types and address decode of the expansion bus master.
  Assumes exb_map.svh on the include path.
*/
`include "exb_map.svh"
package exb_pkg;
  typedef enum logic [1:0] {
    EXB_SZ1 = 2'b00, EXB_SZ2 = 2'b01, EXB_SZ4 = 2'b10, EXB_SZ32 = 2'b11
  } exb_size_t;
  typedef enum logic [2:0] {
    EXB_A_NONE = 3'b000, EXB_A_CTL = 3'b001, EXB_A_ASY = 3'b010,
    EXB_A_SYN = 3'b011, EXB_A_TST = 3'b100
  } exb_area_t;
  typedef enum logic [2:0] {
    EXB_IDLE = 3'b000, EXB_MRD = 3'b001, EXB_AH = 3'b010,
    EXB_AL = 3'b011, EXB_BEAT = 3'b100, EXB_MWR = 3'b101
  } exb_state_t;

  function automatic exb_area_t exb_decode(input logic [31:0] a);
    if (a >= `EXB_CTL_LO && a <= `EXB_CTL_HI) return EXB_A_CTL;
    if (a > `EXB_CTL_HI && a <= `EXB_CTT_HI) return EXB_A_TST;
    if (a >= `EXB_ASY_LO && a <= `EXB_ASY_HI) return EXB_A_ASY;
    if (a > `EXB_ASY_HI && a < `EXB_S16_LO) return EXB_A_TST;
    if (a >= `EXB_S16_LO && a <= `EXB_S16_HI) return EXB_A_SYN;
    if (a > `EXB_S16_HI && a <= `EXB_MOD_HI) return EXB_A_TST;
    if (a >= `EXB_AUD_LO && a <= `EXB_S32_HI) return EXB_A_SYN;
    if (a >= `EXB_MIR_LO && a <= `EXB_S3B_HI) return EXB_A_SYN;
    if (a >= `EXB_EXP_LO && a <= `EXB_EXP_HI) return EXB_A_SYN;
    return EXB_A_NONE;
  endfunction : exb_decode
endpackage : exb_pkg

// File: verif/exb_master_asserts.sv
/* Port checker of exb_master, bound at the foot of this file.
   Assumes one clock domain: clk_sys with synchronous rst_n. */
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// checker
module exb_chk #(
  parameter int unsigned TMO_CYC = 1600
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        cpu_req,
  input wire logic        cpu_we,
  input wire logic [31:0] cpu_addr,
  input wire logic        cpu_ready,
  input wire logic        cpu_rvalid,
  input wire logic        cpu_err,
  input wire logic        mem_req,
  input wire logic        ext_frame,
  input wire logic        ext_ad_oe_n,
  input wire logic [2:0]  ext_irq,
  input wire logic [2:0]  irq_out,
  input wire logic        irq_err
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_take; cpu_req && cpu_ready && !cpu_we; endsequence
  sequence s_done; cpu_rvalid || cpu_err; endsequence
  property p_rst;
    $rose(rst_n) |-> !cpu_ready && !mem_req && !ext_frame && !irq_err;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_idle; !ext_frame |-> ext_ad_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("link driven");
  property p_irq; irq_out == $past(ext_irq, 3); endproperty
  a_irq: assert property (p_irq) else $error("irq copy");
  property p_hold; s_take |=> !cpu_ready || cpu_err; endproperty
  a_hold: assert property (p_hold) else $error("read not held");
  property p_done; s_take |-> ##[1:1000] s_done; endproperty
  a_done: assert property (p_done) else $error("read hung");
  property p_pulse; cpu_rvalid |=> !cpu_rvalid; endproperty
  a_pulse: assert property (p_pulse) else $error("rvalid long");
  property p_nodev;
    cpu_req && cpu_ready && cpu_addr[31:28] == 4'hF |=> cpu_err;
  endproperty
  a_nodev: assert property (p_nodev) else $error("no refusal");
  property p_tst;
    cpu_req && cpu_ready && cpu_addr == 32'h005F_7900 |-> ##[1:3] irq_err;
  endproperty
  a_tst: assert property (p_tst) else $error("no error irq");
endmodule : exb_chk
bind exb_master exb_chk #(.TMO_CYC(TMO_CYC)) exb_chk_inst (.clk_sys, .rst_n,
  .cpu_req, .cpu_we, .cpu_addr, .cpu_ready, .cpu_rvalid, .cpu_err, .mem_req,
  .ext_frame, .ext_ad_oe_n, .ext_irq, .irq_out, .irq_err);
`default_nettype wire

// File: verif/exb_link_tgt.sv
/* Link target model: acks beats, answers reads with a fixed pattern.
   Assumes the master drives the link only inside frames. */
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// target
module exb_link_tgt (
  output logic             ext_clk,
  input  wire logic        ext_frame,
  input  wire logic        ext_write,
  input  wire logic [15:0] ad_bus,
  output logic [15:0]      tgt_ad,
  output logic             ext_ack,
  input  wire logic        slow,
  input  wire logic        absent,
  output logic [31:0]      last32
);
  logic ok;
  // bus clock runs free, so it keeps going between frames
  initial begin
    ext_clk = 1'b0;
    ext_ack = 1'b0;
    tgt_ad = 16'h0000;
    last32 = 32'h0;
    #3;
    forever #62.5 ext_clk = ~ext_clk;
  end
  always @(posedge ext_clk) begin
    // a beat is taken at the very edge whose ack the master sees for it
    ok = ext_frame && !absent && !(slow && ext_ack);
    ext_ack <= ok;
    if (ok && ext_write) begin
      last32 <= {ad_bus, last32[31:16]};
    end
    // released lines toggle so a stale value never passes for data
    tgt_ad <= (ext_frame && !ext_write) ? 16'hC35A : ~tgt_ad;
  end
endmodule : exb_link_tgt
`default_nettype wire

// File: verif/testbench.sv
/* Bench of exb_master with the link target model.
   Assumes exb_map.svh on the include path. */
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// bench
module testbench;
  import exb_pkg::*;
  logic        clk_sys, rst_n, reg_wr, reg_rd, cpu_req, cpu_we, cpu_ready;
  logic        cpu_rvalid, cpu_err, mem_req, mem_we, ext_clk, ext_frame;
  logic        ext_write, ext_ad_oe_n, ext_ack, irq_err, slow, absent, err;
  logic        mem_ack, ext_dreq;
  logic [7:0]  reg_addr;
  logic [15:0] ext_ad_o, tgt_ad, ad_bus;
  logic [2:0]  ext_irq, irq_out;
  logic [31:0] reg_wdata, reg_rdata, cpu_addr, cpu_wdata, cpu_rdata, got;
  logic [31:0] mem_addr, mem_wdata, last32, seed, a, d;
  exb_size_t   cpu_size, ext_size;
  int          error_cnt, check_count, i;
  logic [31:0] bad [4] = '{32'h005F_7800, 32'h0060_0001, 32'h005F_7900,
                           32'hF000_0000};
  assign ad_bus = ext_ad_oe_n ? tgt_ad : ext_ad_o;
  always @(posedge clk_sys) mem_ack <= mem_req & !mem_ack;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // short timeout keeps the no-device case quick
  exb_master #(.TMO_CYC(40)) exb_master_inst (.clk_sys, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_req, .cpu_we, .cpu_addr,
    .cpu_size, .cpu_wdata, .cpu_ready, .cpu_rvalid, .cpu_rdata, .cpu_err,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata(~mem_addr),
    .mem_ack, .ext_clk, .ext_frame, .ext_write, .ext_size, .ext_ad_o,
    .ext_ad_i(ad_bus), .ext_ad_oe_n, .ext_ack, .ext_dreq, .ext_irq,
    .irq_out, .irq_err);
  exb_link_tgt exb_link_tgt_inst (.ext_clk, .ext_frame, .ext_write, .ad_bus,
    .tgt_ad, .ext_ack, .slow, .absent, .last32);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] exp_rd(input logic [31:0] ad);
    return (ad[31:16] == 16'h0060) ? 32'h0000_005A : 32'hC35A_C35A;
  endfunction : exp_rd
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rw(input logic w, input logic [7:0] ad,
                    input logic [31:0] wd);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask : rw
  task automatic cpu(input logic w, input logic [31:0] ad, input exb_size_t s,
                     input logic [31:0] wd);
    int n;
    cpu_we <= w;
    cpu_addr <= ad;
    cpu_size <= s;
    cpu_wdata <= wd;
    cpu_req <= 1'b1;
    n = 0;
    do @(posedge clk_sys); while (cpu_ready !== 1'b1 && ++n < 3000);
    chk("ready", 32'h1, {31'h0, cpu_ready});
    cpu_req <= 1'b0;
    err = 1'b0;
    for (n = 0; n < (w ? 3 : 3000) && !err; n++) begin
      @(posedge clk_sys);
      err = (cpu_rvalid | cpu_err) === 1'b1;
    end
    if (!w) chk("answer", 32'h1, {31'h0, err});
    err = cpu_err;
    got = cpu_rdata;
  endtask : cpu
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #800_000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    seed = 32'h0001_2E0B;
    {rst_n, reg_wr, reg_rd, cpu_req, cpu_we, slow, absent, ext_dreq} = 8'h00;
    {reg_addr, reg_wdata, cpu_addr, cpu_wdata} = 104'h0;
    cpu_size = EXB_SZ4;
    ext_irq = 3'h0;
    error_cnt = 0;
    check_count = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rw(1'b0, 8'h08, 32'h0);
    chk("err flags", 32'h0, got);
    rw(1'b0, 8'h04, 32'h0);
    chk("status", 32'h1, got & 32'hF001);
    for (i = 0; i < 6; i++) begin
      a = 32'h0070_0000 | (rnd() & 32'h000F_FFFC);
      d = rnd();
      slow <= i[0];
      ext_irq <= d[2:0];
      cpu(1'b1, a, EXB_SZ4, d);
      do rw(1'b0, 8'h04, 32'h0); while (!got[0]);
      cpu(1'b0, a, EXB_SZ4, 32'h0);
      chk("read data", exp_rd(a), got);
      chk("link data", d, last32);
      chk("irq copy", {29'h0, d[2:0]}, {29'h0, irq_out});
    end
    cpu(1'b0, 32'h0060_0004, EXB_SZ4, 32'h0);
    chk("async data", exp_rd(32'h0060_0004), got);
    foreach (bad[j]) begin
      cpu(1'b0, bad[j], EXB_SZ1, 32'h0);
      chk("refused", 32'h1, {31'h0, err});
    end
    rw(1'b0, 8'h08, 32'h0);
    chk("size flag", 32'h2, got & 32'h3);
    rw(1'b1, 8'h08, 32'hFFFF_FFFF);
    absent <= 1'b1;
    cpu(1'b0, 32'h0100_0000, EXB_SZ4, 32'h0);
    chk("timeout", 32'h1, {31'h0, err});
    rw(1'b0, 8'h08, 32'h0);
    chk("timeout flag", 32'h1, got & 32'h1);
    chk("err irq", 32'h1, {31'h0, irq_err});
    absent <= 1'b0;
    rw(1'b1, 8'h08, 32'hFFFF_FFFF);
    rw(1'b1, 8'h2C, 32'h1);
    rw(1'b1, 8'h3C, 32'h1);
    rw(1'b0, 8'h08, 32'h0);
    chk("setup flags", 32'h30, got & 32'hF0);
    rw(1'b0, 8'h04, 32'h0);
    chk("no channel", 32'h0, got & 32'hF000);
    rw(1'b1, 8'h30, 32'h0070_0040);
    rw(1'b1, 8'h34, 32'h0000_1000);
    rw(1'b1, 8'h38, 32'h1);
    rw(1'b1, 8'h3C, 32'h5);
    repeat (20) @(posedge clk_sys);
    rw(1'b0, 8'h04, 32'h0);
    chk("dma wait", 32'h2000, got & 32'h2040);
    ext_dreq <= 1'b1;
    do rw(1'b0, 8'h04, 32'h0); while (got[13]);
    chk("dma data", ~32'h0000_101C, last32);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
